/* File: design/rtfa_defs.vh */
// constants of the tag frame and addressing block
`ifndef RTFA_DEFS_VH
`define RTFA_DEFS_VH
// register offsets
`define RTFA_OFS_STATE    8'h00
`define RTFA_OFS_FAMID    8'h04
`define RTFA_OFS_DSFID    8'h08
`define RTFA_OFS_UID_LO   8'h0c
`define RTFA_OFS_UID_HI   8'h10
// lock bit of family and format id registers
`define RTFA_LOCK_BIT     8
// reset values
`define RTFA_FAMID_RST    8'h00
`define RTFA_DSFID_RST    8'h00
// tag states
`define RTFA_TAG_OFF      2'h0
`define RTFA_TAG_READY    2'h1
`define RTFA_TAG_QUIET    2'h2
`define RTFA_TAG_SEL      2'h3
// request flag positions
`define RTFA_RQ_INV       2
`define RTFA_RQ_SEL       4
`define RTFA_RQ_ADR       5
// response flag and error code
`define RTFA_RS_ERR       8'h01
`define RTFA_RS_OK        8'h00
`define RTFA_ERR_OPT      8'h03
// crc
`define RTFA_CRC_PRESET   16'hffff
`define RTFA_CRC_POLY     16'h8408
`define RTFA_CRC_RESIDUE  16'hf0b8
// shortest request: flags, command, two crc bytes
`define RTFA_MIN_LEN      5'h04
// uid bytes start after flags and command
`define RTFA_UID_FIRST    5'h02
`define RTFA_UID_LAST     5'h09
// transmit sequencer
`define RTFA_TX_IDLE      3'h0
`define RTFA_TX_FLAGS     3'h1
`define RTFA_TX_ERR       3'h2
`define RTFA_TX_CRCL      3'h3
`define RTFA_TX_CRCH      3'h4
`endif

/* File: design/rtfa_top.v */
// link-layer framing, crc and addressing of the contactless tag
`timescale 1ns/100ps
`default_nettype none
`include "rtfa_defs.vh"

// Operation
// - 64-bit identifier, read and compared only
// - prefix, maker code, 48-bit serial layout
// - locked application family id never changes
// - family high nibble, subfamily low nibble
// - storage format id writable, lockable
// - crc-16 with all-ones preset per frame
// - two crc bytes end every frame
// - bad crc: drop frame, stay silent
// - lsbyte first, lsbit first ordering
// - answer only after full valid request
// - frames hold whole bytes only
// - request and response field order
// - optional field present when flag set
// - four states: off, ready, quiet, selected
// - off without energy, ready with it
// - ready answers requests without select flag
// - quiet answers only matching addressed requests and select-plus-addressed (error) requests
// - selected answers select, addressed, general
// - addressed request answered on uid match
// - non-addressed request answered by eligible tags
// - select request answered only when selected (select-plus-addressed gets the error answer in ready and quiet too)
// - inventory flag redefines flag bits 5-8
// - error response sets flag bit, code
module rtfa_top #(
  parameter [7:0]  UID_PREFIX = 8'ha5,         // arbitrary value
  parameter [7:0]  MAKER_CODE = 8'h5a,         // arbitrary value
  parameter [47:0] SERIAL     = 48'h0123456789ab
) (
  input  wire        mclk_i,
  input  wire        reset_n_i,
  input  wire        field_ok_i,
  input  wire        rx_sof_i,
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_byte_i,
  input  wire        rx_eof_i,
  input  wire        rx_err_i,
  input  wire        go_quiet_i,
  input  wire        go_select_i,
  input  wire        go_ready_i,
  input  wire        tx_ready_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  output reg  [1:0]  state_o,
  output reg  [7:0]  famid_o,
  output reg  [7:0]  dsfid_o,
  output reg         req_ok_o,
  output reg  [7:0]  req_flags_o,
  output reg  [7:0]  req_cmd_o,
  output reg         tx_valid_o,
  output reg  [7:0]  tx_byte_o,
  output reg         tx_last_o
);

  // ****************************************
  // crc and decode helpers
  // ****************************************
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] r;
    begin
      r = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0])
          r = (r >> 1) ^ `RTFA_CRC_POLY;
        else
          r = r >> 1;
      end
      crc_byte = r;
    end
  endfunction

  function sel_mode;
    input [7:0] f;
    begin
      sel_mode = !f[`RTFA_RQ_INV] && f[`RTFA_RQ_SEL];
    end
  endfunction

  function adr_mode;
    input [7:0] f;
    begin
      adr_mode = !f[`RTFA_RQ_INV] && f[`RTFA_RQ_ADR];
    end
  endfunction

  wire [63:0] uid = {UID_PREFIX, MAKER_CODE, SERIAL};

  // ****************************************
  // state codes
  // ****************************************
  localparam [1:0] S_OFF   = `RTFA_TAG_OFF;
  localparam [1:0] S_READY = `RTFA_TAG_READY;
  localparam [1:0] S_QUIET = `RTFA_TAG_QUIET;
  localparam [1:0] S_SEL   = `RTFA_TAG_SEL;
  localparam [2:0] T_IDLE  = `RTFA_TX_IDLE;
  localparam [2:0] T_FLAGS = `RTFA_TX_FLAGS;
  localparam [2:0] T_ERR   = `RTFA_TX_ERR;
  localparam [2:0] T_CRCL  = `RTFA_TX_CRCL;
  localparam [2:0] T_CRCH  = `RTFA_TX_CRCH;

  // ****************************************
  // registers
  // ****************************************
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [7:0]  famid_reg;
  reg         famid_lock_reg;
  reg  [7:0]  dsfid_reg;
  reg         dsfid_lock_reg;
  reg         in_frame_reg;
  reg         bad_reg;
  reg  [4:0]  len_reg;
  reg  [15:0] crc_reg;
  reg  [7:0]  flags_reg;
  reg  [7:0]  cmd_reg;
  reg  [63:0] uid_rx_reg;
  reg  [2:0]  tx_seq_reg;
  reg         tx_err_reg;
  reg  [15:0] tx_crc_reg;

  wire        tx_busy  = (tx_seq_reg != T_IDLE);
  wire        wr_famid = wr_i && (addr_i == `RTFA_OFS_FAMID);
  wire        wr_dsf  = wr_i && (addr_i == `RTFA_OFS_DSFID);

  // ****************************************
  // request acceptance
  // ****************************************
  reg         frame_good;
  reg         answer;
  reg         opt_err;
  always @* begin
    frame_good = in_frame_reg && rx_eof_i && !bad_reg && !rx_err_i
      && (len_reg >= `RTFA_MIN_LEN)
      && (crc_reg == `RTFA_CRC_RESIDUE) && !tx_busy;
    opt_err = sel_mode(flags_reg) && adr_mode(flags_reg);
    answer  = 1'b0;
    if (state_reg == S_OFF)
      answer = 1'b0;
    else if (opt_err)
      answer = 1'b1;
    else if (sel_mode(flags_reg))
      answer = (state_reg == S_SEL);
    else if (adr_mode(flags_reg))
      answer = (uid_rx_reg == uid) && (len_reg > `RTFA_UID_LAST + 5'h02);
    else
      answer = (state_reg != S_QUIET);
  end

  // ****************************************
  // receive framing and crc check
  // ****************************************
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_frame_reg <= 1'b0;
      bad_reg      <= 1'b0;
      len_reg      <= 5'h00;
      crc_reg      <= `RTFA_CRC_PRESET;
      flags_reg    <= 8'h00;
      cmd_reg      <= 8'h00;
      uid_rx_reg   <= 64'h0;
    end else begin
      if (rx_sof_i) begin
        in_frame_reg <= 1'b1;
        bad_reg      <= 1'b0;
        len_reg      <= 5'h00;
        crc_reg      <= `RTFA_CRC_PRESET;
        uid_rx_reg   <= 64'h0;
      end else if (rx_eof_i || rx_err_i || !field_ok_i) begin
        in_frame_reg <= 1'b0;
      end else if (in_frame_reg && rx_valid_i) begin
        crc_reg <= crc_byte(crc_reg, rx_byte_i);
        if (len_reg != 5'h1f)
          len_reg <= len_reg + 5'h01;
        else
          bad_reg <= 1'b1;
        if (len_reg == 5'h00)
          flags_reg <= rx_byte_i;
        if (len_reg == 5'h01)
          cmd_reg <= rx_byte_i;
        if (len_reg >= `RTFA_UID_FIRST && len_reg <= `RTFA_UID_LAST)
          uid_rx_reg <= {rx_byte_i, uid_rx_reg[63:8]};
      end
    end
  end

  // ****************************************
  // tag state machine
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_OFF:
        if (field_ok_i)
          state_next = S_READY;
      S_READY: begin
        if (go_select_i)
          state_next = S_SEL;
        else if (go_quiet_i)
          state_next = S_QUIET;
      end
      S_QUIET: begin
        if (go_select_i)
          state_next = S_SEL;
        else if (go_ready_i)
          state_next = S_READY;
      end
      S_SEL: begin
        if (go_quiet_i)
          state_next = S_QUIET;
        else if (go_ready_i)
          state_next = S_READY;
      end
      default:
        state_next = S_OFF;
    endcase
    if (!field_ok_i)
      state_next = S_OFF;
  end

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= S_OFF;
      state_o   <= S_OFF;
    end else begin
      state_reg <= state_next;
      state_o   <= state_next;
    end
  end

  // ****************************************
  // identifiers and register port
  // ****************************************
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      famid_reg      <= `RTFA_FAMID_RST;
      famid_lock_reg <= 1'b0;
      dsfid_reg      <= `RTFA_DSFID_RST;
      dsfid_lock_reg <= 1'b0;
      famid_o        <= `RTFA_FAMID_RST;
      dsfid_o        <= `RTFA_DSFID_RST;
      rdata_o        <= 32'h0;
    end else begin
      if (wr_famid && !famid_lock_reg) begin
        famid_reg      <= wdata_i[7:0];
        famid_lock_reg <= wdata_i[`RTFA_LOCK_BIT];
        famid_o        <= wdata_i[7:0];
      end
      if (wr_dsf && !dsfid_lock_reg) begin
        dsfid_reg      <= wdata_i[7:0];
        dsfid_lock_reg <= wdata_i[`RTFA_LOCK_BIT];
        dsfid_o        <= wdata_i[7:0];
      end
      rdata_o <= 32'h0;
      if (rd_i) begin
        case (addr_i)
          `RTFA_OFS_STATE:  rdata_o <= {30'h0, state_reg};
          `RTFA_OFS_FAMID:  rdata_o <= {23'h0, famid_lock_reg, famid_reg};
          `RTFA_OFS_DSFID:  rdata_o <= {23'h0, dsfid_lock_reg, dsfid_reg};
          `RTFA_OFS_UID_LO: rdata_o <= uid[31:0];
          `RTFA_OFS_UID_HI: rdata_o <= uid[63:32];
          default:          rdata_o <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // request hand-off and response framer
  // ****************************************
  wire [7:0] rs_flags = opt_err ? `RTFA_RS_ERR : `RTFA_RS_OK;
  wire       tx_step  = tx_valid_o && tx_ready_i;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_ok_o    <= 1'b0;
      req_flags_o <= 8'h00;
      req_cmd_o   <= 8'h00;
      tx_seq_reg  <= T_IDLE;
      tx_err_reg  <= 1'b0;
      tx_crc_reg  <= `RTFA_CRC_PRESET;
      tx_valid_o  <= 1'b0;
      tx_byte_o   <= 8'h00;
      tx_last_o   <= 1'b0;
    end else begin
      req_ok_o <= 1'b0;
      if (!field_ok_i) begin
        tx_seq_reg <= T_IDLE;
        tx_valid_o <= 1'b0;
        tx_last_o  <= 1'b0;
      end else if (frame_good && answer) begin
        req_ok_o    <= !opt_err;
        req_flags_o <= flags_reg;
        req_cmd_o   <= cmd_reg;
        tx_err_reg  <= opt_err;
        tx_crc_reg  <= crc_byte(`RTFA_CRC_PRESET, rs_flags);
        tx_seq_reg  <= T_FLAGS;
        tx_byte_o   <= rs_flags;
        tx_valid_o  <= 1'b1;
        tx_last_o   <= 1'b0;
      end else if (tx_step) begin
        case (tx_seq_reg)
          T_FLAGS: begin
            if (tx_err_reg) begin
              tx_seq_reg <= T_ERR;
              tx_byte_o  <= `RTFA_ERR_OPT;
              tx_crc_reg <= crc_byte(tx_crc_reg, `RTFA_ERR_OPT);
            end else begin
              tx_seq_reg <= T_CRCL;
              tx_byte_o  <= ~tx_crc_reg[7:0];
            end
          end
          T_ERR: begin
            tx_seq_reg <= T_CRCL;
            tx_byte_o  <= ~tx_crc_reg[7:0];
          end
          T_CRCL: begin
            tx_seq_reg <= T_CRCH;
            tx_byte_o  <= ~tx_crc_reg[15:8];
            tx_last_o  <= 1'b1;
          end
          T_CRCH: begin
            tx_seq_reg <= T_IDLE;
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
          end
          default: begin
            tx_seq_reg <= T_IDLE;
            tx_valid_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // rtfa_top
`default_nettype wire

/* File: test/rtfa_checker.sv */
// assertions on the ports of the tag frame and addressing block
`timescale 1ns/100ps
`default_nettype none
`include "rtfa_defs.vh"
module rtfa_checker (
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic        field_ok_i,
  input wire logic        rx_eof_i,
  input wire logic        tx_ready_i,
  input wire logic [7:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0]  state_o,
  input wire logic        req_ok_o,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_byte_o,
  input wire logic        tx_last_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_state_rd; rd_i && addr_i == `RTFA_OFS_STATE; endsequence
  sequence s_err_head; $rose(tx_valid_o) && tx_ready_i && tx_byte_o == `RTFA_RS_ERR; endsequence
  a_state_read: assert property (s_state_rd |=> rdata_o == {30'h0, $past(state_o)})
    else $error("state read wrong");
  a_field_off: assert property (!field_ok_i |=> state_o == `RTFA_TAG_OFF)
    else $error("no off state without field");
  a_ready_entry: assert property (
    state_o == `RTFA_TAG_OFF && field_ok_i |=> state_o == `RTFA_TAG_READY)
    else $error("no ready state with field");
  a_no_unasked: assert property ($rose(tx_valid_o) |-> $past(rx_eof_i))
    else $error("response without request");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("byte lost while stalled");
  a_ok_flags: assert property (req_ok_o |-> tx_valid_o && tx_byte_o == `RTFA_RS_OK)
    else $error("accepted response flags wrong");
  a_err_code: assert property (s_err_head |=> tx_valid_o && tx_byte_o == `RTFA_ERR_OPT)
    else $error("error code wrong");
  a_last_bound: assert property ($rose(tx_valid_o) |-> ##[2:200] tx_last_o)
    else $error("response never ends");
endmodule // rtfa_checker
bind rtfa_top rtfa_checker u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .field_ok_i(field_ok_i),
  .rx_eof_i(rx_eof_i), .tx_ready_i(tx_ready_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .state_o(state_o), .req_ok_o(req_ok_o), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
  .tx_last_o(tx_last_o));
`default_nettype wire

/* File: test/rtfa_reader.sv */
// reader model: sends request frames, collects responses
`timescale 1ns/100ps
`default_nettype none
module rtfa_reader #(
  parameter logic [63:0] UID = 64'h0
) (
  input wire logic       mclk_i,
  input wire logic       tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic       tx_last_i,
  output logic           sof_o,
  output logic           vld_o,
  output logic [7:0]     byte_o,
  output logic           eof_o,
  output logic           rdy_o
);
  logic [7:0] rsp[$];
  logic       done = 1'b0;
  logic [7:0] cmd  = 8'h00;
  int         seed = 32'h5de8;
  initial {sof_o, vld_o, byte_o, eof_o, rdy_o} = 12'h0;
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  // random stalls, response checked later by the bench
  always @(posedge mclk_i) begin
    rdy_o <= 1'($random(seed));
    if (tx_valid_i && rdy_o) begin
      rsp.push_back(tx_byte_i);
      if (tx_last_i)
        done <= 1'b1;
    end
  end
  task automatic send(input logic [7:0] f, input logic um, input logic cok);
    logic [7:0]  q[$];
    logic [15:0] c;
    cmd = 8'($random(seed));
    q = {f, cmd};
    if (f[5] && !f[2] && !f[4])
      for (int i = 0; i < 8; i++)
        q.push_back(UID[8*i +: 8] ^ {7'h0, !um});
    c = 16'hffff;
    foreach (q[i])
      c = crc16(c, q[i]);
    c = ~c ^ {15'h0, !cok};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    @(posedge mclk_i) sof_o <= 1'b1;
    foreach (q[i]) begin
      @(posedge mclk_i) sof_o <= 1'b0;
      vld_o  <= 1'b1;
      byte_o <= q[i];
    end
    @(posedge mclk_i) vld_o <= 1'b0;
    byte_o <= ~byte_o;
    eof_o  <= 1'b1;
    @(posedge mclk_i) eof_o <= 1'b0;
  endtask
endmodule // rtfa_reader
`default_nettype wire

/* File: test/rf_tag_frame_addressing_bench.sv */
// self-checking bench of the tag frame and addressing block
`timescale 1ns/100ps
`default_nettype none
`include "rtfa_defs.vh"
module rf_tag_frame_addressing_bench;
  localparam logic [7:0]  PFX = 8'h3c; // arbitrary value
  localparam logic [7:0]  MKR = 8'hc3; // arbitrary value
  localparam logic [47:0] SER = 48'h0a1b2c3d4e5f;
  localparam logic [11:0] CT [12] = '{12'h403, 12'h443, 12'h483, 12'h481, 12'h402, 12'h4c3,
                                     12'h453, 12'h803, 12'h883, 12'h8c3, 12'hc43, 12'hc03};
  logic        mclk_i = 1'b0, reset_n_i = 1'b0, field_ok = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        gq = 1'b0, gs = 1'b0, gr = 1'b0, sof, vld, eof, rdy, txv, txl, um, cok;
  logic        rqok, rxe = 1'b0;
  logic [7:0]  addr = 8'h00, f, v, a, famid, dsfid, rqf, rqc, txb, rxb;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  cur, s;
  int          fail_count = 0, total_checks = 0, seed = 32'h5de8, cyc = 0, e, ok_n = 0;
  rtfa_top #(.UID_PREFIX(PFX), .MAKER_CODE(MKR), .SERIAL(SER)) u_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .field_ok_i(field_ok), .rx_sof_i(sof),
    .rx_valid_i(vld), .rx_byte_i(rxb), .rx_eof_i(eof), .rx_err_i(rxe), .go_quiet_i(gq),
    .go_select_i(gs), .go_ready_i(gr), .tx_ready_i(rdy), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .state_o(cur), .famid_o(famid), .dsfid_o(dsfid),
    .req_ok_o(rqok), .req_flags_o(rqf), .req_cmd_o(rqc), .tx_valid_o(txv), .tx_byte_o(txb),
    .tx_last_o(txl));
  rtfa_reader #(.UID({PFX, MKR, SER})) u_rd (.mclk_i(mclk_i), .tx_valid_i(txv),
    .tx_byte_i(txb), .tx_last_i(txl), .sof_o(sof), .vld_o(vld), .byte_o(rxb), .eof_o(eof),
    .rdy_o(rdy));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk_i) wr <= w;
    rd    <= !w;
    addr  <= ad;
    wdata <= d;
    @(posedge mclk_i) wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic go(input logic [1:0] n);
    @(posedge mclk_i) gr <= n == 2'd1;
    gq <= n == 2'd2;
    gs <= n == 2'd3;
    @(posedge mclk_i) {gr, gq, gs} <= 3'b000;
    #1;
  endtask
  function automatic int expect_rsp(input logic [1:0] n, input logic [7:0] fl, input logic ok, m);
    if (!ok || n == `RTFA_TAG_OFF)
      return 0;
    if (fl[2] || !fl[5] && !fl[4])
      return int'(n != `RTFA_TAG_QUIET);
    if (fl[4] && fl[5])
      return 2;
    if (fl[5])
      return int'(m);
    return int'(n == `RTFA_TAG_SEL);
  endfunction
  task automatic frame(input logic [1:0] n);
    logic [15:0] c;
    int          k;
    k = ok_n;
    u_rd.rsp.delete();
    u_rd.done = 1'b0;
    u_rd.send(f, um, cok);
    for (int w = 0; w < 60 && !u_rd.done; w++)
      @(posedge mclk_i);
    e = rxe ? 0 : expect_rsp(n, f, cok, um);
    c = 16'hffff;
    for (int i = 0; i < u_rd.rsp.size(); i++)
      c = u_rd.crc16(c, u_rd.rsp[i]);
    chk("rsp_len", u_rd.rsp.size(), e == 0 ? 0 : e == 2 ? 4 : 3);
    if (e != 0) begin
      chk("rsp_flags", u_rd.rsp[0], e == 2 ? `RTFA_RS_ERR : `RTFA_RS_OK);
      chk("rsp_crc", c, `RTFA_CRC_RESIDUE);
    end
    if (e == 2)
      chk("err_code", u_rd.rsp[1], `RTFA_ERR_OPT);
    chk("req_ok", ok_n - k, e == 1);
    if (e == 1) begin
      chk("req_flags", rqf, f);
      chk("req_cmd", rqc, u_rd.cmd);
    end
  endtask
  initial forever #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (rqok)
      ok_n++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    field_ok  <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1 chk("state", cur, `RTFA_TAG_READY);
    bus(1'b1, `RTFA_OFS_UID_LO, 32'h0);
    bus(1'b0, `RTFA_OFS_UID_LO, 32'h0);
    chk("uid_lo", rdata, SER[31:0]);
    bus(1'b0, `RTFA_OFS_UID_HI, 32'h0);
    chk("uid_hi", rdata, {PFX, MKR, SER[47:32]});
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", rdata, 32'h0);
    for (int i = 0; i < 2; i++) begin
      v = 8'($random(seed));
      a = i ? `RTFA_OFS_DSFID : `RTFA_OFS_FAMID;
      bus(1'b1, a, {24'h0, v});
      bus(1'b1, a, {23'h0, 1'b1, v});
      bus(1'b1, a, {24'h0, ~v});
      bus(1'b0, a, 32'h0);
      chk("id_reg", rdata, {23'h0, 1'b1, v});
      chk("id_out", i ? dsfid : famid, v);
    end
    for (int n = 0; n < 60; n++) begin
      {s, f, um, cok} = CT[n % 12];
      if (n >= 12) begin
        s   = 2'(1 + {$random(seed)} % 3);
        f   = 8'($random(seed));
        um  = 1'($random(seed));
        cok = ({$random(seed)} % 4) != 0;
      end
      // coding error held across some random frames
      rxe <= n >= 12 && ({$random(seed)} % 8) == 0;
      go(s);
      chk("state", cur, s);
      bus(1'b0, `RTFA_OFS_STATE, 32'h0);
      chk("state_reg", rdata, {30'h0, s});
      frame(s);
    end
    field_ok <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 chk("state", cur, `RTFA_TAG_OFF);
    {f, um, cok} = 10'h003;
    frame(`RTFA_TAG_OFF);
    print_verdict;
  end
endmodule // rf_tag_frame_addressing_bench
`default_nettype wire
